// [rtl/lpsq_pkg.sv]
package lpsq_pkg;

    // register byte offsets
    localparam logic [7:0] A_SETTLE  = 8'h00;
    localparam logic [7:0] A_CTRL    = 8'h04;
    localparam logic [7:0] A_STATE   = 8'h08;
    localparam logic [7:0] A_IRQ_ST  = 8'h0C;
    localparam logic [7:0] A_IRQ_MSK = 8'h10;
    localparam logic [7:0] A_WMASK1  = 8'h14;
    localparam logic [7:0] A_WMASK2  = 8'h18;
    localparam logic [7:0] A_WFACT1  = 8'h1C;
    localparam logic [7:0] A_WFACT2  = 8'h20;
    localparam logic [7:0] A_WCLR1   = 8'h24;
    localparam logic [7:0] A_WCLR2   = 8'h28;
    localparam logic [7:0] A_HOLD1   = 8'h2C;
    localparam logic [7:0] A_HOLD2   = 8'h30;

    // field positions
    localparam int SETTLE_LSB   = 8;
    localparam int SETTLE_W     = 8;
    localparam int SEL_HI_BIT   = 7;
    localparam int SEL_LO_LSB   = 2;
    localparam int AEN_BIT      = 1;
    localparam int DEN_BIT      = 0;
    localparam int ACT_BIT      = 0;
    localparam int DIG_WAKE_BIT = 0;
    localparam int FLT_WAKE_BIT = 1;
    localparam int SCAN_LO      = 14;
    localparam int SCAN_HI      = 18;
    localparam int IRQ_START    = 0;
    localparam int IRQ_TRIG     = 1;
    localparam int IRQ_RANGE    = 2;
    localparam int IRQ_W        = 3;

    // values after reset
    localparam logic [31:0] WMASK_RST = 32'hFFFFFFFF;
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [7:0]  SETL_RST  = 8'h00;

    // settling: fast oscillator divided by 20, sixteen ticks per count
    localparam int SETTLE_DIV  = 20;
    localparam int SETTLE_MULT = 16;
    localparam int SETTLE_CYC  = SETTLE_DIV * SETTLE_MULT;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        S_IDLE   = 2'b00,
        S_SETTLE = 2'b01,
        S_DIG    = 2'b10
    } lpsq_state_e;

endpackage

// [rtl/lpsq_settle_if.sv]
`timescale 1ns/1ps
interface lpsq_settle_if;
    logic       start;
    logic [7:0] cnt;
    logic       done;
    modport ctl (output start, output cnt, input done);
    modport tmr (input start, input cnt, output done);
endinterface

// [rtl/lpsq_settle.sv]
`timescale 1ns/1ps
module lpsq_settle (
    input  wire logic   core_clk,
    input  wire logic   rst,
    lpsq_settle_if.tmr  sif
);
    logic [4:0]  div_q,  div_d;
    logic [11:0] left_q, left_d;
    logic        run_q,  run_d;
    logic        done_q, done_d;
    logic        tick;

    assign tick = (div_q == 5'(lpsq_pkg::SETTLE_DIV - 1));
    assign sif.done = done_q;

    always_comb begin
        div_d  = div_q;
        left_d = left_q;
        run_d  = run_q;
        done_d = 1'b0;
        if (sif.start) begin
            run_d  = 1'b1;
            div_d  = 5'h00;
            left_d = {sif.cnt, 4'h0};
        end else if (run_q) begin
            if (left_q == 12'h000) begin
                run_d  = 1'b0;
                done_d = 1'b1;
            end else begin
                div_d = tick ? 5'h00 : div_q + 5'h01;
                if (tick) begin
                    left_d = left_q - 12'h001;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q  <= 5'h00;
            left_q <= 12'h000;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            left_q <= left_d;
            run_q  <= run_d;
            done_q <= done_d;
        end
    end
endmodule // lpsq_settle

// [rtl/lpsq_wake.sv]
`timescale 1ns/1ps
module lpsq_wake #(
    parameter int W = 32
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] ev,
    input  wire logic [W-1:0] mask,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] fact
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic q, d;
            // an unmasked event wins over a clear in the same cycle
            always_comb begin
                d = q;
                if (clr[i]) begin
                    d = 1'b0;
                end
                if (ev[i] && !mask[i]) begin
                    d = 1'b1;
                end
            end
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    q <= 1'b0;
                end else begin
                    q <= d;
                end
            end
            assign fact[i] = q;
        end
    endgenerate
endmodule // lpsq_wake

// [rtl/lpsq_top.sv]
// Operation
// - settle count at bits 15:8; wait is 16 x count x 20 oscillator cycles
// - timer channel chosen by select bit 7 and select field bits 3:2
// - control bit 1 enables analog input mode
// - after sensor power rises, trigger conversion once the settle time ends
// - a readable state register shows whether a sequence runs
// - analog fault wake accepted only while first wake mask bit 1 is 0
// - scan end wake of group x enabled by second mask bit x, 14 to 18
// - writing 1 to a wake clear bit clears that latched wake factor
// - writing 0 to both pin hold registers releases the held pins
// - with both modes enabled both polling sequences run together
// - an expiry of the chosen timer channel while idle starts one sequence; expiries during a sequence are ignored
// - busy flag reads 1 during a sequence and 0 otherwise
// - range error raises its interrupt and the analog fault wake factor
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module lpsq_top (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  timer_expiry,
    input  wire logic        digital_seq_done,
    input  wire logic        digital_mismatch,
    input  wire logic        range_error_irq,
    input  wire logic [4:0]  scan_group_end_irq,
    input  wire logic        standby_entry,
    output logic             sensor_power_out,
    output logic             conv_trigger,
    output logic             digital_seq_start,
    output logic             analog_fault_wake,
    output logic             wake_request,
    output logic             pin_hold_first,
    output logic             pin_hold_second,
    output logic             irq
);
    // ---------------- bus slave ----------------
    logic [7:0]  waddr_q, waddr_d;
    logic        wpend_q, wpend_d;
    logic [31:0] rdat_q,  rdat_d;
    logic        we;
    logic [31:0] wclr1, wclr2;

    // ---------------- configuration ----------------
    logic [7:0]                     ctrl_q,  ctrl_d;
    logic [lpsq_pkg::SETTLE_W-1:0]  setl_q,  setl_d;
    logic [lpsq_pkg::IRQ_W-1:0]     ist_q,   ist_d;
    logic [lpsq_pkg::IRQ_W-1:0]     imsk_q,  imsk_d;
    logic [31:0]                    wm1_q,   wm1_d;
    logic [31:0]                    wm2_q,   wm2_d;
    logic                           hold1_q, hold1_d;
    logic                           hold2_q, hold2_d;
    logic                           irq_q,   irq_d;
    logic                           wreq_q,  wreq_d;

    // ---------------- sequencer ----------------
    lpsq_pkg::lpsq_state_e          st_q,    st_d;
    logic                           act_q,   act_d;
    logic                           pwr_q,   pwr_d;
    logic                           trig_q,  trig_d;
    logic                           dst_q,   dst_d;
    logic                           dpend_q, dpend_d;
    logic                           flt_q,   flt_d;
    logic                           aen, den, sel_exp;
    logic [2:0]                     sel;
    logic [31:0]                    fact1, fact2, ev2;

    lpsq_settle_if sif ();

    lpsq_settle u_settle (
        .core_clk (core_clk),
        .rst      (rst),
        .sif      (sif)
    );

    assign aen = ctrl_q[lpsq_pkg::AEN_BIT];
    assign den = ctrl_q[lpsq_pkg::DEN_BIT];
    assign sel = {ctrl_q[lpsq_pkg::SEL_HI_BIT],
                  ctrl_q[lpsq_pkg::SEL_LO_LSB +: 2]};
    assign sel_exp = timer_expiry[sel];

    assign we = wpend_q;

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h00000000;
        case (a)
            lpsq_pkg::A_SETTLE:  r[lpsq_pkg::SETTLE_LSB +: 8] = setl_q;
            lpsq_pkg::A_CTRL:    r[7:0] = ctrl_q;
            lpsq_pkg::A_STATE:   r[lpsq_pkg::ACT_BIT] = act_q;
            lpsq_pkg::A_IRQ_ST:  r[lpsq_pkg::IRQ_W-1:0] = ist_q;
            lpsq_pkg::A_IRQ_MSK: r[lpsq_pkg::IRQ_W-1:0] = imsk_q;
            lpsq_pkg::A_WMASK1:  r = wm1_q;
            lpsq_pkg::A_WMASK2:  r = wm2_q;
            lpsq_pkg::A_WFACT1:  r = fact1;
            lpsq_pkg::A_WFACT2:  r = fact2;
            lpsq_pkg::A_HOLD1:   r[0] = hold1_q;
            lpsq_pkg::A_HOLD2:   r[0] = hold2_q;
            default:             r = 32'h00000000;
        endcase
        return r;
    endfunction

    // zero wait states: read data is fetched during the address phase
    always_comb begin
        wpend_d = 1'b0;
        waddr_d = waddr_q;
        rdat_d  = rdat_q;
        if (hsel && hready && htrans[1]) begin
            waddr_d = haddr[7:0];
            wpend_d = hwrite && (hsize == lpsq_pkg::HSIZE_WORD);
            if (!hwrite) begin
                rdat_d = rd_word(haddr[7:0]);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            waddr_q <= 8'h00;
            wpend_q <= 1'b0;
            rdat_q  <= 32'h00000000;
        end else begin
            waddr_q <= waddr_d;
            wpend_q <= wpend_d;
            rdat_q  <= rdat_d;
        end
    end

    assign hrdata    = rdat_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign wclr1 = (we && waddr_q == lpsq_pkg::A_WCLR1) ? hwdata
                                                         : 32'h00000000;
    assign wclr2 = (we && waddr_q == lpsq_pkg::A_WCLR2) ? hwdata
                                                         : 32'h00000000;

    // ---------------- wake factor latches ----------------
    always_comb begin
        ev2 = 32'h00000000;
        ev2[lpsq_pkg::SCAN_HI:lpsq_pkg::SCAN_LO] = scan_group_end_irq;
    end

    lpsq_wake #(.W(32)) u_wake1 (
        .core_clk (core_clk),
        .rst      (rst),
        .ev       ({30'h00000000, flt_q, digital_mismatch}),
        .mask     (wm1_q),
        .clr      (wclr1),
        .fact     (fact1)
    );

    lpsq_wake #(.W(32)) u_wake2 (
        .core_clk (core_clk),
        .rst      (rst),
        .ev       (ev2),
        .mask     (wm2_q),
        .clr      (wclr2),
        .fact     (fact2)
    );

    // ---------------- configuration registers ----------------
    always_comb begin
        ctrl_d  = ctrl_q;
        setl_d  = setl_q;
        imsk_d  = imsk_q;
        wm1_d   = wm1_q;
        wm2_d   = wm2_q;
        hold1_d = hold1_q;
        hold2_d = hold2_q;
        ist_d   = ist_q;
        if (we) begin
            case (waddr_q)
                lpsq_pkg::A_SETTLE: begin
                    if (!aen && !den && !act_q) begin
                        setl_d = hwdata[lpsq_pkg::SETTLE_LSB +: 8];
                    end
                end
                lpsq_pkg::A_CTRL: begin
                    ctrl_d = hwdata[7:0];
                    if (aen || den || act_q) begin
                        ctrl_d[lpsq_pkg::SEL_HI_BIT] =
                            ctrl_q[lpsq_pkg::SEL_HI_BIT];
                        ctrl_d[lpsq_pkg::SEL_LO_LSB +: 2] =
                            ctrl_q[lpsq_pkg::SEL_LO_LSB +: 2];
                    end
                end
                lpsq_pkg::A_IRQ_ST:
                    ist_d = ist_q & ~hwdata[lpsq_pkg::IRQ_W-1:0];
                lpsq_pkg::A_IRQ_MSK:
                    imsk_d = hwdata[lpsq_pkg::IRQ_W-1:0];
                lpsq_pkg::A_WMASK1:  wm1_d = hwdata;
                lpsq_pkg::A_WMASK2:  wm2_d = hwdata;
                lpsq_pkg::A_HOLD1:   hold1_d = hold1_q & hwdata[0];
                lpsq_pkg::A_HOLD2:   hold2_d = hold2_q & hwdata[0];
                default: ;
            endcase
        end
        if (standby_entry) begin
            hold1_d = 1'b1;
            hold2_d = 1'b1;
        end
        // hardware set wins over a same-cycle write-one clear
        ist_d[lpsq_pkg::IRQ_START] = ist_d[lpsq_pkg::IRQ_START]
            | (st_q == lpsq_pkg::S_IDLE && act_d);
        ist_d[lpsq_pkg::IRQ_TRIG]  = ist_d[lpsq_pkg::IRQ_TRIG] | trig_d;
        ist_d[lpsq_pkg::IRQ_RANGE] = ist_d[lpsq_pkg::IRQ_RANGE]
            | range_error_irq;
        irq_d  = |(ist_q & ~imsk_q);
        wreq_d = (|fact1) || (|fact2);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q  <= lpsq_pkg::CTRL_RST;
            setl_q  <= lpsq_pkg::SETL_RST;
            ist_q   <= '0;
            imsk_q  <= '1;
            wm1_q   <= lpsq_pkg::WMASK_RST;
            wm2_q   <= lpsq_pkg::WMASK_RST;
            hold1_q <= 1'b0;
            hold2_q <= 1'b0;
            irq_q   <= 1'b0;
            wreq_q  <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            setl_q  <= setl_d;
            ist_q   <= ist_d;
            imsk_q  <= imsk_d;
            wm1_q   <= wm1_d;
            wm2_q   <= wm2_d;
            hold1_q <= hold1_d;
            hold2_q <= hold2_d;
            irq_q   <= irq_d;
            wreq_q  <= wreq_d;
        end
    end

    // ---------------- polling sequencer ----------------
    assign sif.cnt = setl_q;

    always_comb begin
        st_d      = st_q;
        act_d     = act_q;
        pwr_d     = pwr_q;
        trig_d    = 1'b0;
        dst_d     = 1'b0;
        dpend_d   = dpend_q && !digital_seq_done;
        sif.start = 1'b0;
        flt_d     = range_error_irq;
        case (st_q)
            lpsq_pkg::S_IDLE: begin
                if (sel_exp && (aen || den)) begin
                    act_d   = 1'b1;
                    dst_d   = den;
                    dpend_d = den;
                    if (aen) begin
                        pwr_d     = 1'b1;
                        sif.start = 1'b1;
                        st_d      = lpsq_pkg::S_SETTLE;
                    end else begin
                        st_d = lpsq_pkg::S_DIG;
                    end
                end
            end
            lpsq_pkg::S_SETTLE: begin
                if (sif.done) begin
                    trig_d = 1'b1;
                    pwr_d  = 1'b0;
                    if (dpend_d) begin
                        st_d = lpsq_pkg::S_DIG;
                    end else begin
                        st_d  = lpsq_pkg::S_IDLE;
                        act_d = 1'b0;
                    end
                end
            end
            lpsq_pkg::S_DIG: begin
                if (!dpend_d) begin
                    st_d  = lpsq_pkg::S_IDLE;
                    act_d = 1'b0;
                end
            end
            default: begin
                st_d  = lpsq_pkg::S_IDLE;
                act_d = 1'b0;
                pwr_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q    <= lpsq_pkg::S_IDLE;
            act_q   <= 1'b0;
            pwr_q   <= 1'b0;
            trig_q  <= 1'b0;
            dst_q   <= 1'b0;
            dpend_q <= 1'b0;
            flt_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            act_q   <= act_d;
            pwr_q   <= pwr_d;
            trig_q  <= trig_d;
            dst_q   <= dst_d;
            dpend_q <= dpend_d;
            flt_q   <= flt_d;
        end
    end

    assign sensor_power_out  = pwr_q;
    assign conv_trigger      = trig_q;
    assign digital_seq_start = dst_q;
    assign analog_fault_wake = flt_q;
    assign wake_request      = wreq_q;
    assign pin_hold_first    = hold1_q;
    assign pin_hold_second   = hold2_q;
    assign irq               = irq_q;

    // ---------------- checks ----------------
    logic [16:0] pw_cnt_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pw_cnt_q <= 17'h00000;
        end else begin
            pw_cnt_q <= pwr_q ? pw_cnt_q + 17'h00001 : 17'h00000;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_start;
        st_q == lpsq_pkg::S_IDLE && sel_exp && (aen || den);
    endsequence

    sequence s_mixed_start;
        s_start ##0 (aen && den);
    endsequence

    a_settle_time: assert property (
        $rose(conv_trigger) |-> pw_cnt_q ==
            17'(setl_q) * 17'(lpsq_pkg::SETTLE_CYC) + 17'h00002)
        else $error("trigger not at end of settle time");

    a_start_busy: assert property (
        s_start |=> act_q && (sensor_power_out || digital_seq_start))
        else $error("timer expiry did not start a sequence");

    a_mixed_both: assert property (
        s_mixed_start |=> digital_seq_start && sensor_power_out)
        else $error("mixed mode did not start both sequences");

    a_idle_quiet: assert property (
        st_q == lpsq_pkg::S_IDLE && !aen && !den |=> !act_q)
        else $error("sequence started while disabled");

    a_trig_idle: assert property (
        conv_trigger && !dpend_q |-> !act_q && !sensor_power_out)
        else $error("sequencer not idle after trigger");

    a_fault_wake: assert property (
        range_error_irq |=> analog_fault_wake
            ##1 (fact1[lpsq_pkg::FLT_WAKE_BIT]
                 || $past(wm1_q[lpsq_pkg::FLT_WAKE_BIT])))
        else $error("range error did not reach wake factor");

    a_fault_mask: assert property (
        $rose(fact1[lpsq_pkg::FLT_WAKE_BIT]) |->
            !$past(wm1_q[lpsq_pkg::FLT_WAKE_BIT]))
        else $error("masked fault wake was latched");

    a_scan_range: assert property (
        fact2[31:lpsq_pkg::SCAN_HI+1] == '0
            && fact2[lpsq_pkg::SCAN_LO-1:0] == '0
            && ($past(ev2) & ~$past(wm2_q) & ~fact2) == 32'h00000000)
        else $error("scan wake missing or outside groups 14 to 18");

    a_wake_clear: assert property (
        wclr1[lpsq_pkg::FLT_WAKE_BIT] && !flt_q
            |=> !fact1[lpsq_pkg::FLT_WAKE_BIT])
        else $error("wake clear did not clear factor");

    a_hold_release: assert property (
        we && waddr_q == lpsq_pkg::A_HOLD1 && !hwdata[0]
            && !standby_entry |=> !pin_hold_first)
        else $error("pin hold not released");
endmodule // lpsq_top

// [sim/lpsq_adc_model.sv]
`timescale 1ns/1ps
module lpsq_adc_model #(
    parameter logic [5:0] OUR_SEL = 6'h2A, // arbitrary trigger code
    parameter int         LAT     = 4
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       conv_trigger,
    input  wire logic       trig_en,
    input  wire logic [5:0] trig_sel,
    input  wire logic       out_of_range,
    output logic            range_error_irq,
    output logic      [4:0] scan_group_end_irq
);
    logic [7:0] pipe_q;
    logic       hit;
    assign hit = conv_trigger & trig_en & (trig_sel == OUR_SEL);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) pipe_q <= 8'h00;
        else pipe_q <= {pipe_q[6:0], hit};
    end
    // scan group 14 ends, limit check fails when commanded
    assign scan_group_end_irq = {4'h0, pipe_q[LAT-1]};
    assign range_error_irq    = pipe_q[LAT-1] & out_of_range;
endmodule // lpsq_adc_model

// [sim/low_power_analog_poll_sequencer_bench.sv]
`timescale 1ns/1ps
module low_power_analog_poll_sequencer_bench;
    logic        core_clk, rst, hsel, hwrite, standby_entry, oor;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  timer_expiry;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, sensor_power_out, conv_trigger, irq;
    logic        wake_request, pin_hold_first, pin_hold_second, range_err;
    logic        dig_done, dig_start;
    logic [4:0]  scan_end;
    int          fails, n_checks, run_n, last_n;

    lpsq_top i_dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .timer_expiry, .digital_seq_done(dig_done), .digital_mismatch(1'b0),
        .range_error_irq(range_err), .scan_group_end_irq(scan_end),
        .standby_entry, .sensor_power_out, .conv_trigger,
        .digital_seq_start(dig_start), .analog_fault_wake(), .wake_request,
        .pin_hold_first, .pin_hold_second, .irq);

    lpsq_adc_model i_adc (.core_clk, .rst, .conv_trigger, .trig_en(1'b1),
        .trig_sel(6'h2A), .out_of_range(oor), .range_error_irq(range_err),
        .scan_group_end_irq(scan_end));

    // length of each power-on window, in clock cycles
    always @(posedge core_clk) begin
        if (sensor_power_out) run_n <= run_n + 1;
        else if (conv_trigger) begin
            last_n <= run_n;
            run_n <= 0;
        end
    end

    task report_and_stop;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task hwait;
        for (int i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (hreadyout === 1'b1) return;
        end
        fails++;
        report_and_stop();
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= lpsq_pkg::HSIZE_WORD;
        hwait();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        hwait();
        r = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        chk(n, e, r);
    endtask
    task pulse_ch(input int ch);
        timer_expiry <= 8'h01 << ch;
        cyc(1);
        timer_expiry <= 8'h00;
    endtask

    task t_reset;
        rdc("wmask1", lpsq_pkg::A_WMASK1, lpsq_pkg::WMASK_RST);
        rdc("ctrl", lpsq_pkg::A_CTRL, 32'h00000000);
        rdc("state", lpsq_pkg::A_STATE, 32'h00000000);
        rdc("unmapped", 8'hFC, 32'h00000000);
        $display("reset values done");
    endtask
    task t_seq(input logic [7:0] cnt);
        wr(lpsq_pkg::A_CTRL, 32'h00000000);
        wr(lpsq_pkg::A_SETTLE, {16'h0000, cnt, 8'h00});
        wr(lpsq_pkg::A_CTRL, 32'h00000086);
        pulse_ch(4);
        cyc(1);
        chk("power wrong ch", 32'h0, {31'h0, sensor_power_out});
        pulse_ch(5);
        cyc(1);
        chk("power on", 32'h1, {31'h0, sensor_power_out});
        if (cnt != 8'h00) rdc("busy", lpsq_pkg::A_STATE, 32'h1);
        for (int i = 0; i <= 2000 && conv_trigger !== 1'b1; i++) begin
            if (i == 2000) begin
                fails++;
                report_and_stop();
            end
            cyc(1);
        end
        cyc(1);
        chk("settle cycles", 320 * cnt + 2, last_n);
        chk("power off", 32'h0, {31'h0, sensor_power_out});
        rdc("idle", lpsq_pkg::A_STATE, 32'h0);
        wr(lpsq_pkg::A_SETTLE, 32'h0000FF00);
        rdc("settle kept", lpsq_pkg::A_SETTLE, {16'h0, cnt, 8'h0});
        $display("sequence count %0d done", cnt);
    endtask
    task t_mixed;
        wr(lpsq_pkg::A_CTRL, 32'h00000000);
        wr(lpsq_pkg::A_SETTLE, 32'h00000000);
        wr(lpsq_pkg::A_CTRL, 32'h00000087);
        pulse_ch(5);
        cyc(1);
        chk("mixed dig start", 32'h1, {31'h0, dig_start});
        chk("mixed power", 32'h1, {31'h0, sensor_power_out});
        cyc(3);
        chk("mixed settle", 32'h2, last_n);
        chk("mixed power off", 32'h0, {31'h0, sensor_power_out});
        rdc("mixed busy", lpsq_pkg::A_STATE, 32'h1);
        dig_done <= 1'b1;
        cyc(1);
        dig_done <= 1'b0;
        cyc(1);
        rdc("mixed idle", lpsq_pkg::A_STATE, 32'h0);
        $display("mixed mode test done");
    endtask
    task t_wake;
        oor <= 1'b1;
        t_seq(8'h00);
        cyc(10);
        rdc("masked fault", lpsq_pkg::A_WFACT1, 32'h0);
        wr(lpsq_pkg::A_WMASK1, 32'hFFFFFFFD);
        wr(lpsq_pkg::A_WMASK2, 32'hFFFFBFFF);
        wr(lpsq_pkg::A_IRQ_MSK, 32'hFFFFFFFB);
        t_seq(8'h00);
        cyc(10);
        chk("wake req", 32'h1, {31'h0, wake_request});
        chk("irq", 32'h1, {31'h0, irq});
        rdc("fault fact", lpsq_pkg::A_WFACT1, 32'h2);
        rdc("scan fact", lpsq_pkg::A_WFACT2, 32'h4000);
        rdc("irq status", lpsq_pkg::A_IRQ_ST, 32'h7);
        oor <= 1'b0;
        wr(lpsq_pkg::A_WCLR1, 32'h2);
        wr(lpsq_pkg::A_WCLR2, 32'h4000);
        wr(lpsq_pkg::A_IRQ_ST, 32'h7);
        cyc(2);
        rdc("fact clr", lpsq_pkg::A_WFACT1, 32'h0);
        rdc("scan clr", lpsq_pkg::A_WFACT2, 32'h0);
        chk("wake low", 32'h0, {31'h0, wake_request});
        chk("irq low", 32'h0, {31'h0, irq});
        $display("wake test done");
    endtask
    task t_hold;
        standby_entry <= 1'b1;
        cyc(1);
        standby_entry <= 1'b0;
        cyc(2);
        chk("hold 1 set", 32'h1, {31'h0, pin_hold_first});
        chk("hold 2 set", 32'h1, {31'h0, pin_hold_second});
        wr(lpsq_pkg::A_HOLD1, 32'h0);
        wr(lpsq_pkg::A_HOLD2, 32'h0);
        cyc(1);
        chk("hold 1 free", 32'h0, {31'h0, pin_hold_first});
        chk("hold 2 free", 32'h0, {31'h0, pin_hold_second});
        $display("pin hold test done");
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        {rst, hsel, hwrite, standby_entry, oor, dig_done} = 6'h20;
        {haddr, hwdata, htrans, hsize, timer_expiry} = '0;
        {fails, n_checks, run_n, last_n} = '0;
        cyc(5);
        rst <= 1'b0;
        t_reset();
        t_seq(8'h01);
        t_seq(8'h00);
        t_mixed();
        t_wake();
        t_hold();
        report_and_stop();
    end
endmodule // low_power_analog_poll_sequencer_bench
